// >>> hdl/cts_sequencer.sv
// Purpose: pc / next_pc sequencing, delay slots, annulment, linking, window moves
// Assumes: instValid marks the completing instruction; condTrue is its evaluated condition
// Notes: register file lives outside; this block drives its read indexes and write port
`timescale 1ns/1ns
module cts_sequencer (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic instValid,
    input wire logic [31:0] instWord,
    input wire logic condTrue,
    input wire logic [31:0] srcOneData,
    input wire logic [31:0] srcTwoData,
    input wire logic [7:0] window_invalid_mask,
    input wire logic [31:0] trapTarget,
    output logic [4:0] srcOneIdx,
    output logic [4:0] srcTwoIdx,
    output logic [31:0] pc,
    output logic [31:0] next_pc,
    output logic [cts_pkg::WIN_W-1:0] current_window_pointer,
    output logic slotAnnulled,
    output logic windowFault,
    output cts_pkg::cts_wr_t rfWrite
);
    cts_pkg::cts_dec_t dec;
    logic [31:0] opOne, opTwo, sum, relTarget, callTarget;
    logic taken, isAlways, annulPending;
    logic [cts_pkg::WIN_W-1:0] newCwp;
    logic [31:0] next_pcReg, next_npc;
    logic [cts_pkg::WIN_W-1:0] next_cwp;
    logic next_annul, next_fault;
    cts_pkg::cts_wr_t next_wr;

    // operand fetch and target arithmetic
    always_comb begin
        dec = cts_pkg::cts_decode(instWord);
        srcOneIdx = dec.srcOne;
        srcTwoIdx = dec.srcTwo;
        opOne = (dec.srcOne == 5'h00) ? 32'h0000_0000 : srcOneData;
        opTwo = (dec.srcTwo == 5'h00) ? 32'h0000_0000 : srcTwoData;
        sum = opOne + (dec.useImm ? dec.shortImm : opTwo);
        relTarget = pc + dec.branchDisp;
        callTarget = pc + dec.callDisp;
        isAlways = (dec.cond == cts_pkg::COND_ALWAYS);
        taken = isAlways || ((dec.cond != cts_pkg::COND_NEVER) && condTrue);
        newCwp = dec.isSave ? current_window_pointer - 3'h1 : current_window_pointer + 3'h1;
    end

    assign slotAnnulled = annulPending;

    // next state of the sequencer
    always_comb begin
        next_pcReg = pc;
        next_npc = next_pc;
        next_cwp = current_window_pointer;
        next_annul = annulPending;
        next_fault = 1'b0;
        next_wr = '0;
        if (instValid) begin
            next_pcReg = next_pc;
            next_npc = next_pc + cts_pkg::PC_STEP;
            if (annulPending) begin
                // annulled slot only advances the counters
                next_annul = 1'b0;
            end else if (dec.isCall) begin
                // target lands in next_pc, one slot later
                next_npc = callTarget;
                next_wr = '{en: 1'b1, window: current_window_pointer,
                            idx: cts_pkg::LINK_REG, data: pc};
            end else if (dec.isBranch) begin
                // delay slot is whatever next_pc holds
                if (taken) begin
                    next_npc = relTarget;
                end
                if (dec.annul && isAlways) begin
                    // skip the slot, go straight to target
                    next_pcReg = relTarget;
                    next_npc = relTarget + cts_pkg::PC_STEP;
                end else if (dec.annul && !taken) begin
                    // not taken with annul kills the slot
                    next_annul = 1'b1;
                end
                // annul clear leaves the slot to execute
            end else if (dec.isJumpLink) begin
                next_npc = sum;
                next_wr = '{en: (dec.dest != 5'h00), window: current_window_pointer,
                            idx: dec.dest, data: pc};
            end else if (dec.isTrap) begin
                // taken trap has no delay slot
                if (taken) begin
                    next_pcReg = trapTarget;
                    next_npc = trapTarget + cts_pkg::PC_STEP;
                end
            end else if (dec.isSave || dec.isRestore) begin
                // invalid window holds the instruction back
                if (window_invalid_mask[newCwp]) begin
                    next_fault = 1'b1;
                    next_pcReg = pc;
                    next_npc = next_pc;
                end else begin
                    // save moves down; restore moves up
                    next_cwp = newCwp;
                    next_wr = '{en: (dec.dest != 5'h00), window: newCwp,
                                idx: dec.dest, data: sum};
                end
            end
        end
    end

    // state registers; write port and fault are one-cycle pulses
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc <= cts_pkg::RESET_PC;
            next_pc <= cts_pkg::RESET_PC + cts_pkg::PC_STEP;
            current_window_pointer <= cts_pkg::RESET_CWP;
            annulPending <= 1'b0;
            windowFault <= 1'b0;
            rfWrite <= '0;
        end else begin
            pc <= next_pcReg;
            next_pc <= next_npc;
            current_window_pointer <= next_cwp;
            annulPending <= next_annul;
            windowFault <= next_fault;
            rfWrite <= next_wr;
        end
    end

    // checks
    logic liveNow;
    assign liveNow = instValid && !annulPending;

    property p_seq_advance;
        @(posedge sys_clk) disable iff (rst)
        (liveNow && !dec.isCall && !dec.isBranch && !dec.isJumpLink && !dec.isTrap
         && !dec.isSave && !dec.isRestore)
        |=> (pc == $past(next_pc)) && (next_pc == $past(next_pc) + 32'h0000_0004);
    endproperty
    a_seq_advance: assert property (p_seq_advance) else $error("sequential advance wrong");

    property p_branch_target;
        @(posedge sys_clk) disable iff (rst)
        (liveNow && dec.isBranch && taken && !(dec.annul && isAlways))
        |=> next_pc == $past(pc) + $past(dec.branchDisp);
    endproperty
    a_branch_target: assert property (p_branch_target) else $error("branch target wrong");

    property p_call_link;
        @(posedge sys_clk) disable iff (rst)
        (liveNow && dec.isCall) |=> rfWrite.en && rfWrite.idx == 5'h0f
        && rfWrite.data == $past(pc) && next_pc == $past(pc) + $past(dec.callDisp);
    endproperty
    a_call_link: assert property (p_call_link) else $error("call link wrong");

    property p_jump_link;
        @(posedge sys_clk) disable iff (rst)
        (liveNow && dec.isJumpLink) |=> next_pc == $past(sum)
        && rfWrite.en == ($past(dec.dest) != 5'h00) && rfWrite.data == $past(pc);
    endproperty
    a_jump_link: assert property (p_jump_link) else $error("jump and link wrong");

    property p_annul_cond;
        @(posedge sys_clk) disable iff (rst)
        (liveNow && dec.isBranch && dec.annul && !isAlways)
        |=> annulPending == !$past(taken);
    endproperty
    a_annul_cond: assert property (p_annul_cond) else $error("conditional annul wrong");

    property p_annul_quiet;
        @(posedge sys_clk) disable iff (rst)
        (instValid && annulPending) |=> !rfWrite.en && !windowFault
        && current_window_pointer == $past(current_window_pointer) && !annulPending;
    endproperty
    a_annul_quiet: assert property (p_annul_quiet) else $error("annulled slot had effect");

    property p_always_skip;
        @(posedge sys_clk) disable iff (rst)
        (liveNow && dec.isBranch && dec.annul && isAlways)
        |=> pc == $past(relTarget) && next_pc == $past(relTarget) + 32'h0000_0004;
    endproperty
    a_always_skip: assert property (p_always_skip) else $error("branch always skip wrong");

    property p_window_move;
        @(posedge sys_clk) disable iff (rst)
        (liveNow && dec.isSave && !window_invalid_mask[newCwp])
        |=> current_window_pointer == $past(current_window_pointer) - 3'h1;
    endproperty
    a_window_move: assert property (p_window_move) else $error("save pointer wrong");

    property p_window_restore;
        @(posedge sys_clk) disable iff (rst)
        (liveNow && dec.isRestore && !window_invalid_mask[newCwp])
        |=> current_window_pointer == $past(current_window_pointer) + 3'h1
        && rfWrite.window == current_window_pointer && rfWrite.data == $past(sum);
    endproperty
    a_window_restore: assert property (p_window_restore) else $error("restore wrong");

    property p_window_fault;
        @(posedge sys_clk) disable iff (rst)
        (liveNow && (dec.isSave || dec.isRestore) && window_invalid_mask[newCwp])
        |=> windowFault && !rfWrite.en && pc == $past(pc);
    endproperty
    a_window_fault: assert property (p_window_fault) else $error("window check wrong");

    property p_no_reg_zero;
        @(posedge sys_clk) disable iff (rst)
        rfWrite.en |-> rfWrite.idx != 5'h00;
    endproperty
    a_no_reg_zero: assert property (p_no_reg_zero) else $error("write to register zero");

    property p_trap_jump;
        @(posedge sys_clk) disable iff (rst)
        (liveNow && dec.isTrap && taken) |=> pc == $past(trapTarget);
    endproperty
    a_trap_jump: assert property (p_trap_jump) else $error("trap transfer wrong");

    c_annul_slot: cover property (@(posedge sys_clk) disable iff (rst)
        annulPending ##1 !annulPending);
    c_window_fault: cover property (@(posedge sys_clk) disable iff (rst) windowFault);
    c_call: cover property (@(posedge sys_clk) disable iff (rst) liveNow && dec.isCall);
    c_always_skip: cover property (@(posedge sys_clk) disable iff (rst)
        liveNow && dec.isBranch && dec.annul && isAlways);
endmodule : cts_sequencer

// >>> hdl/cts_pkg.sv
// Purpose: constants, types and instruction decode for the control transfer sequencer
// Assumes: 32-bit instruction words, eight register windows
// Notes on behaviour
// - pc-relative target is pc plus sign-extended displacement times four
// - indirect target is source one plus source two or short immediate
// - delayed transfer reaches its target after exactly one delay instruction
// - completion copies next_pc to pc, next_pc gets plus four or target
// - the delay instruction is whatever next_pc addresses
// - only branches, conditional, always and never alike, honour the annul bit
// - conditional branch with annul set skips delay slot only when not taken
// - annulled instruction changes no state and raises no trap
// - branch-always with annul set skips delay slot, acting non-delayed
// - annul clear always executes the delay instruction
// - call writes its own address into register fifteen
// - jump_and_link writes its own address into its destination register
// - save adds from old window, decrements window pointer, writes new window
// - restore adds from current window, increments pointer, writes new window
// - save and restore check updated pointer against window_invalid_mask
// - call displacement is 30 bits, branch displacement 22 bits
// - register zero reads as zero and writes to it are dropped
// - taken conditional trap jumps without delay slot, else no-operation
package cts_pkg;
    localparam int WIN_W = 3;
    localparam logic [31:0] RESET_PC = 32'h0000_0000;
    localparam logic [31:0] PC_STEP = 32'h0000_0004;
    localparam logic [WIN_W-1:0] RESET_CWP = 3'h0;
    localparam logic [4:0] LINK_REG = 5'h0f;
    localparam logic [1:0] OP_FMT2 = 2'h0;
    localparam logic [1:0] OP_CALL = 2'h1;
    localparam logic [1:0] OP_FMT3 = 2'h2;
    localparam logic [2:0] OP2_INT_BR = 3'h2;
    localparam logic [2:0] OP2_FP_BR = 3'h6;
    localparam logic [2:0] OP2_COP_BR = 3'h7;
    localparam logic [5:0] OP3_JUMP_LINK = 6'h38;
    localparam logic [5:0] OP3_TRAP = 6'h3a;
    localparam logic [5:0] OP3_SAVE = 6'h3c;
    localparam logic [5:0] OP3_RESTORE = 6'h3d;
    localparam logic [3:0] COND_NEVER = 4'h0;
    localparam logic [3:0] COND_ALWAYS = 4'h8;

    typedef struct packed {
        logic isCall;
        logic isBranch;
        logic isJumpLink;
        logic isTrap;
        logic isSave;
        logic isRestore;
        logic annul;
        logic useImm;
        logic [3:0] cond;
        logic [4:0] dest;
        logic [4:0] srcOne;
        logic [4:0] srcTwo;
        logic [31:0] branchDisp;
        logic [31:0] callDisp;
        logic [31:0] shortImm;
    } cts_dec_t;

    typedef struct packed {
        logic en;
        logic [WIN_W-1:0] window;
        logic [4:0] idx;
        logic [31:0] data;
    } cts_wr_t;

    // field split of one instruction word
    function automatic cts_dec_t cts_decode(input logic [31:0] w);
        cts_dec_t d;
        d.isCall = (w[31:30] == OP_CALL);
        d.isBranch = (w[31:30] == OP_FMT2) && (w[24:22] == OP2_INT_BR
                     || w[24:22] == OP2_FP_BR || w[24:22] == OP2_COP_BR);
        d.isJumpLink = (w[31:30] == OP_FMT3) && (w[24:19] == OP3_JUMP_LINK);
        d.isTrap = (w[31:30] == OP_FMT3) && (w[24:19] == OP3_TRAP);
        d.isSave = (w[31:30] == OP_FMT3) && (w[24:19] == OP3_SAVE);
        d.isRestore = (w[31:30] == OP_FMT3) && (w[24:19] == OP3_RESTORE);
        d.annul = w[29];
        d.useImm = w[13];
        d.cond = w[28:25];
        d.dest = w[29:25];
        d.srcOne = w[18:14];
        d.srcTwo = w[4:0];
        d.branchDisp = {{8{w[21]}}, w[21:0], 2'b00};
        d.callDisp = {w[29:0], 2'b00};
        d.shortImm = {{19{w[12]}}, w[12:0]};
        return d;
    endfunction : cts_decode
endpackage : cts_pkg

// >>> tb/cts_sequencer_bench.sv
// Purpose: self-checking bench for the control transfer sequencer
// Assumes: register data and trap target held at fixed values, inputs move on falling edge
// Notes: one row per completing instruction, rows run back to back from reset state
`timescale 1ns/1ns
module cts_sequencer_bench;
    typedef struct packed {
        logic [31:0] w;
        logic c;
        logic [7:0] m;
        logic [31:0] ePc;
        logic [31:0] eNpc;
        logic [2:0] eCwp;
        logic eAnn;
        logic eFlt;
        logic eEn;
        logic [2:0] eWin;
        logic [4:0] eIdx;
        logic [31:0] eData;
    } cts_row_t;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic instValid = 1'b0;
    logic [31:0] instWord = 32'h0100_0000;
    logic condTrue = 1'b0;
    logic [31:0] srcOneData = 32'h100;
    logic [31:0] srcTwoData = 32'h20;
    logic [7:0] window_invalid_mask = 8'h00;
    logic [31:0] trapTarget = 32'h200;
    logic [4:0] srcOneIdx;
    logic [4:0] srcTwoIdx;
    logic [31:0] pc;
    logic [31:0] next_pc;
    logic [2:0] current_window_pointer;
    logic slotAnnulled;
    logic windowFault;
    cts_pkg::cts_wr_t rfWrite;
    cts_row_t rows [20];
    int errCount = 0;
    int nTests = 0;

`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin errCount++; \
    $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end

    cts_sequencer dut_u (.sys_clk(sys_clk), .rst(rst), .instValid(instValid),
        .instWord(instWord), .condTrue(condTrue), .srcOneData(srcOneData),
        .srcTwoData(srcTwoData), .window_invalid_mask(window_invalid_mask),
        .trapTarget(trapTarget), .srcOneIdx(srcOneIdx), .srcTwoIdx(srcTwoIdx), .pc(pc),
        .next_pc(next_pc), .current_window_pointer(current_window_pointer),
        .slotAnnulled(slotAnnulled), .windowFault(windowFault), .rfWrite(rfWrite));

    // 125 MHz processor clock
    always #4 sys_clk = ~sys_clk;

    // counts line, verdict, end of run
    task automatic stopTest();
        $display("comparisons %0d, mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stopTest

    // reset-state check, reused after the mid-run reset
    task automatic checkReset();
        `CHK(pc, 32'h0)
        `CHK(next_pc, 32'h4)
        `CHK({current_window_pointer, slotAnnulled, windowFault, rfWrite.en}, 6'h00)
    endtask : checkReset

    // watchdog: the whole run needs well under a hundred cycles
    initial begin
        repeat (2000) @(posedge sys_clk);
        errCount++;
        stopTest();
    end

    initial begin
        // word, cond, mask, pc, next_pc, cwp, annulled, fault, wr en, window, index, data
        rows[0] = '{32'h4000_0004, 1'b0, 8'h00, 32'h4, 32'h10, 3'h0,
                    1'b0, 1'b0, 1'b1, 3'h0, 5'h0f, 32'h0};
        rows[1] = '{32'h0100_0000, 1'b0, 8'h00, 32'h10, 32'h14, 3'h0,
                    1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        rows[2] = '{32'h3080_0003, 1'b1, 8'h00, 32'h1c, 32'h20, 3'h0,
                    1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        rows[3] = '{32'h22bf_fffe, 1'b0, 8'h00, 32'h20, 32'h24, 3'h0,
                    1'b1, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        rows[4] = '{32'h4000_0004, 1'b0, 8'h00, 32'h24, 32'h28, 3'h0,
                    1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        rows[5] = '{32'h23bf_fffe, 1'b1, 8'h00, 32'h28, 32'h1c, 3'h0,
                    1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        rows[6] = '{32'h0100_0000, 1'b0, 8'h00, 32'h1c, 32'h20, 3'h0,
                    1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        rows[7] = '{32'h03c0_0004, 1'b0, 8'h00, 32'h20, 32'h24, 3'h0,
                    1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        rows[8] = '{32'h8bc0_7ffc, 1'b0, 8'h00, 32'h24, 32'hfc, 3'h0,
                    1'b0, 1'b0, 1'b1, 3'h0, 5'h05, 32'h20};
        rows[9] = '{32'h81c0_4002, 1'b0, 8'h00, 32'hfc, 32'h120, 3'h0,
                    1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        rows[10] = '{32'h87e0_4002, 1'b0, 8'h00, 32'h120, 32'h124, 3'h7,
                     1'b0, 1'b0, 1'b1, 3'h7, 5'h03, 32'h120};
        rows[11] = '{32'h89e8_6005, 1'b0, 8'h00, 32'h124, 32'h128, 3'h0,
                     1'b0, 1'b0, 1'b1, 3'h0, 5'h04, 32'h105};
        rows[12] = '{32'h87e0_4002, 1'b0, 8'h80, 32'h124, 32'h128, 3'h0,
                     1'b0, 1'b1, 1'b0, 3'h0, 5'h00, 32'h0};
        rows[13] = '{32'h0100_0000, 1'b0, 8'h00, 32'h128, 32'h12c, 3'h0,
                     1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        rows[14] = '{32'h91d0_0000, 1'b1, 8'h00, 32'h200, 32'h204, 3'h0,
                     1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        rows[15] = '{32'h83d0_0000, 1'b0, 8'h00, 32'h204, 32'h208, 3'h0,
                     1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        // branch always with annul clear keeps its slot
        rows[16] = '{32'h1080_0004, 1'b0, 8'h00, 32'h208, 32'h214, 3'h0,
                     1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        rows[17] = '{32'h0100_0000, 1'b0, 8'h00, 32'h214, 32'h218, 3'h0,
                     1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        // register zero as source reads zero, as destination drops the link
        rows[18] = '{32'h81c0_2040, 1'b0, 8'h00, 32'h218, 32'h40, 3'h0,
                     1'b0, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        // branch never ignores a true condition and annuls its slot
        rows[19] = '{32'h2080_0004, 1'b1, 8'h00, 32'h40, 32'h44, 3'h0,
                     1'b1, 1'b0, 1'b0, 3'h0, 5'h00, 32'h0};
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        checkReset();
        // rows: call, delay slot, branch kinds, annulled slot, links, windows, traps
        for (int i = 0; i < 20; i++) begin
            instValid = 1'b1;
            instWord = rows[i].w;
            condTrue = rows[i].c;
            window_invalid_mask = rows[i].m;
            @(negedge sys_clk);
            `CHK(pc, rows[i].ePc)
            `CHK(next_pc, rows[i].eNpc)
            `CHK(current_window_pointer, rows[i].eCwp)
            `CHK(slotAnnulled, rows[i].eAnn)
            `CHK(windowFault, rows[i].eFlt)
            `CHK(rfWrite.en, rows[i].eEn)
            if (rows[i].eEn) begin
                `CHK(rfWrite.window, rows[i].eWin)
                `CHK(rfWrite.idx, rows[i].eIdx)
                `CHK(rfWrite.data, rows[i].eData)
            end
        end
        // idle edges hold every counter; read indexes follow the word at once
        instValid = 1'b0;
        instWord = 32'h81c0_4002;
        repeat (3) @(negedge sys_clk);
        `CHK({pc, next_pc}, {32'h40, 32'h44})
        `CHK(rfWrite.en, 1'b0)
        `CHK(slotAnnulled, 1'b1)
        `CHK({srcOneIdx, srcTwoIdx}, {5'h01, 5'h02})
        // second reset in mid-run returns to the start state
        rst = 1'b1;
        @(negedge sys_clk);
        rst = 1'b0;
        checkReset();
        stopTest();
    end
endmodule : cts_sequencer_bench
